// [hdl/ccss_consts.svh]
`ifndef CCSS_CONSTS_SVH
`define CCSS_CONSTS_SVH

// Clock rate and operation-complete wait
`define CCSS_CLK_KHZ 125000
`define CCSS_OPC_WAIT_MS 2000

// Setting locations
`define CCSS_LOC_STD 8'h00
`define CCSS_LOC_FIRST 8'h01
`define CCSS_LOC_LAST 8'h13

// Reply and enable register
`define CCSS_ASCII_ONE 8'h31
`define CCSS_SRE_RESET 8'h00
`define CCSS_SRE_MSS_BIT 6
`define CCSS_SRE_ESB_BIT 5
`define CCSS_SRE_MAV_BIT 4
`define CCSS_SRE_LOW_BIT 0

// Standard setting values
`define CCSS_RST_THRESH_MV 16'h0000
`define CCSS_RST_COUNT 16'h0001
`define CCSS_RST_PERIOD_NS 32'h000f_4240
`define CCSS_RST_WIDTH_NS 32'h0001_86a0
`define CCSS_RST_DELAY_NS 32'h0000_0000
`define CCSS_RST_DOUBLE_NS 32'h0003_0d40
`define CCSS_RST_DUTY_PCT 7'h32
`define CCSS_RST_HIGH_MV 16'h01f4
`define CCSS_RST_LOW_MV 16'hfe0c

`endif

// [hdl/ccss_pkg.sv]
`default_nettype none

package ccss_pkg;

  typedef enum logic [2:0] {
    cmd_opc_query  = 3'h0,
    cmd_recall     = 3'h1,
    cmd_save       = 3'h2,
    cmd_reset      = 3'h3,
    cmd_clear      = 3'h4,
    cmd_sre_write  = 3'h5,
    cmd_sre_query  = 3'h6
  } ccss_cmd_code_type;

  typedef struct packed {
    logic              valid;
    ccss_cmd_code_type code;
    logic [7:0]        arg;
  } ccss_cmd_type;

  // Gray along idle -> drain -> wait
  typedef enum logic [1:0] {
    st_idle  = 2'b00,
    st_drain = 2'b01,
    st_wait  = 2'b11
  } ccss_state_type;

  typedef enum logic [2:0] {
    mode_auto  = 3'h0,
    mode_trig  = 3'h1,
    mode_gate  = 3'h2,
    mode_burst = 3'h3,
    mode_ewid  = 3'h4,
    mode_trans = 3'h5
  } ccss_trig_mode_type;

  typedef struct packed {
    logic [31:0] width_ns;
    logic [31:0] delay_ns;
    logic [31:0] double_ns;
    logic        double_mode;
    logic [6:0]  duty_pct;
    logic        duty_mode;
    logic [15:0] high_mv;
    logic [15:0] low_mv;
    logic        limit_on;
    logic        pol_comp;
    logic        out_en;
    logic        complement_output_enable;
  } ccss_chan_type;

  typedef struct packed {
    logic               trig_en;
    ccss_trig_mode_type trig_mode;
    logic               slope_neg;
    logic [15:0]        thresh_mv;
    logic [15:0]        burst_count;
    logic [31:0]        period_ns;
    ccss_chan_type [1:0] ch;
  } ccss_setting_type;

endpackage

`default_nettype wire

// [hdl/ccss_top.sv]
// Function
// - Operation-complete query: drain parsed input, wait two seconds, reply ASCII one.
// - Power-on, device clear, clear or reset abandon a pending completion query.
// - Recall takes location 0 to 19 and activates the stored setting.
// - Location zero gives the standard setting; 1 to 19 give saved settings.
// - Reset loads the standard setting, cancels completion wait, goes idle.
// - Reset empties the front-panel key queue.
// - Reset keeps interface state, address, output queue and enable registers.
// - Standard trigger: disabled, automatic, positive slope, zero volts, count one.
// - Standard channel timing, levels, modes, polarity and outputs as defined.
// - Save takes location 1 to 19 and stores the active setting there.
// - A saved setting holds exactly the standard setting's parameter set.
// - Enable write takes 0 to 255 and stores it in the enable register.
// - Enable register clears at power-on or on zero; reset and clear keep it.
// - Enable bits 6, 5, 4, 0 gate status bits; 7, 3, 2, 1 unused.
// - Enable query returns the register contents, 0 to 255.
`timescale 1ns/1ps
`include "ccss_consts.svh"
`default_nettype none

module ccss_top #(
  parameter int unsigned OPC_WAIT_CYCLES = `CCSS_OPC_WAIT_MS * `CCSS_CLK_KHZ
) (
  // Clock and power-on reset
  input  wire logic                       ref_clk,
  input  wire logic                       reset,
  // Parsed command stream
  input  wire ccss_pkg::ccss_cmd_type     cmd,
  input  wire logic                       queue_empty,
  input  wire logic                       dev_clear,
  // Replies to the output queue
  output logic                            resp_valid_q,
  output logic [7:0]                      resp_data_q,
  output logic                            cmd_error_q,
  output logic                            opc_busy_q,
  output logic                            key_queue_clear_q,
  // Active setting and enables
  output ccss_pkg::ccss_setting_type      active_q,
  output logic [7:0]                      sre_q,
  output logic [7:0]                      srq_mask_q
);

  // Standard setting held as a constant
  function automatic ccss_pkg::ccss_setting_type std_setting();
    ccss_pkg::ccss_setting_type s;
    s.trig_en     = 1'b0;
    s.trig_mode   = ccss_pkg::mode_auto;
    s.slope_neg   = 1'b0;
    s.thresh_mv   = `CCSS_RST_THRESH_MV;
    s.burst_count = `CCSS_RST_COUNT;
    s.period_ns   = `CCSS_RST_PERIOD_NS;
    for (int i = 0; i < 2; i++) begin
      s.ch[i].width_ns    = `CCSS_RST_WIDTH_NS;
      s.ch[i].delay_ns    = `CCSS_RST_DELAY_NS;
      s.ch[i].double_ns   = `CCSS_RST_DOUBLE_NS;
      s.ch[i].double_mode = 1'b0;
      s.ch[i].duty_pct    = `CCSS_RST_DUTY_PCT;
      s.ch[i].duty_mode   = 1'b0;
      s.ch[i].high_mv     = `CCSS_RST_HIGH_MV;
      s.ch[i].low_mv      = `CCSS_RST_LOW_MV;
      s.ch[i].limit_on    = 1'b0;
      s.ch[i].pol_comp    = 1'b0;
      s.ch[i].out_en      = 1'b0;
      s.ch[i].complement_output_enable = 1'b0;
    end
    return s;
  endfunction

  // Location range check shared by recall and save
  function automatic logic loc_ok(input logic [7:0] a, input logic [7:0] lo);
    return (a >= lo) && (a <= `CCSS_LOC_LAST);
  endfunction

  // Sequencer state; 28 bits cover two seconds at the full clock rate
  ccss_pkg::ccss_state_type   state_q;
  logic [27:0]                cnt_q;
  // Nineteen writable copies in flip-flops; area traded for a single-cycle recall
  ccss_pkg::ccss_setting_type store_q [1:19];
  ccss_pkg::ccss_setting_type pick;
  logic [4:0]                 loc;
  // Decoded strobes, one per command code
  logic is_opc, is_rcl, is_sav, is_rst, is_cls, is_srew, is_sreq;
  logic rcl_ok, sav_ok, bad_loc, cancel, opc_done;

  // Command decode
  assign is_opc  = cmd.valid && cmd.code == ccss_pkg::cmd_opc_query;
  assign is_rcl  = cmd.valid && cmd.code == ccss_pkg::cmd_recall;
  assign is_sav  = cmd.valid && cmd.code == ccss_pkg::cmd_save;
  assign is_rst  = cmd.valid && cmd.code == ccss_pkg::cmd_reset;
  assign is_cls  = cmd.valid && cmd.code == ccss_pkg::cmd_clear;
  assign is_srew = cmd.valid && cmd.code == ccss_pkg::cmd_sre_write;
  assign is_sreq = cmd.valid && cmd.code == ccss_pkg::cmd_sre_query;
  assign loc     = cmd.arg[4:0];
  // Range checks; save starts above the fixed location zero
  assign rcl_ok  = is_rcl && loc_ok(cmd.arg, `CCSS_LOC_STD);
  assign sav_ok  = is_sav && loc_ok(cmd.arg, `CCSS_LOC_FIRST);
  assign bad_loc = (is_rcl && !rcl_ok) || (is_sav && !sav_ok);
  // Location zero reads the fixed copy, which no save can overwrite
  assign pick    = (loc == 5'h00) ? std_setting() : store_q[loc];
  assign cancel  = dev_clear || is_rst || is_cls;
  // An enable query in the same cycle delays the ASCII one by a cycle
  assign opc_done = state_q == ccss_pkg::st_wait && cnt_q == 28'h0
                    && !cancel && !is_sreq;

  // Completion query sequencer
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_q <= ccss_pkg::st_idle;
      cnt_q   <= 28'h0;
    end else begin
      case (state_q)
        ccss_pkg::st_idle: begin
          // A query arriving under device clear is dropped at once
          if (is_opc && !dev_clear)
            state_q <= ccss_pkg::st_drain;
        end
        ccss_pkg::st_drain: begin
          if (cancel) begin
            state_q <= ccss_pkg::st_idle;
          end else if (queue_empty) begin
            state_q <= ccss_pkg::st_wait;
            cnt_q   <= 28'(OPC_WAIT_CYCLES - 1);
          end
        end
        ccss_pkg::st_wait: begin
          if (cancel || opc_done)
            state_q <= ccss_pkg::st_idle;
          else if (cnt_q != 28'h0)
            cnt_q <= cnt_q - 28'h1;
        end
        default: state_q <= ccss_pkg::st_idle;
      endcase
    end
  end

  // Busy flag mirrors the sequencer a cycle later
  always_ff @(posedge ref_clk) begin
    if (reset)
      opc_busy_q <= 1'b0;
    else
      opc_busy_q <= state_q != ccss_pkg::st_idle;
  end

  // Output queue replies; an enable query wins and the completion reply follows a cycle later
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      resp_valid_q <= 1'b0;
      resp_data_q  <= 8'h00;
    end else begin
      resp_valid_q <= opc_done || is_sreq;
      if (opc_done)
        resp_data_q <= `CCSS_ASCII_ONE;
      else if (is_sreq)
        resp_data_q <= sre_q;
    end
  end

  // Error pulse: bad location, or completion query already pending
  always_ff @(posedge ref_clk) begin
    if (reset)
      cmd_error_q <= 1'b0;
    else
      cmd_error_q <= bad_loc || (is_opc && state_q != ccss_pkg::st_idle);
  end

  // Key queue flush pulse
  always_ff @(posedge ref_clk) begin
    if (reset)
      key_queue_clear_q <= 1'b0;
    else
      key_queue_clear_q <= is_rst;
  end

  // Active setting; reset and location zero use the fixed copy
  always_ff @(posedge ref_clk) begin
    if (reset)
      active_q <= std_setting();
    else if (is_rst)
      active_q <= std_setting();
    else if (rcl_ok)
      active_q <= pick;
  end

  // Writable locations; same type as the standard setting
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      for (int i = 1; i <= 19; i++)
        store_q[i] <= std_setting();
    end else if (sav_ok) begin
      store_q[loc] <= active_q;
    end
  end

  // Enable register; only power-on or a written zero clears it
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sre_q      <= `CCSS_SRE_RESET;
      srq_mask_q <= `CCSS_SRE_RESET;
    end else if (is_srew) begin
      sre_q      <= cmd.arg;
      srq_mask_q <= '0;
      srq_mask_q[`CCSS_SRE_MSS_BIT] <= cmd.arg[`CCSS_SRE_MSS_BIT];
      srq_mask_q[`CCSS_SRE_ESB_BIT] <= cmd.arg[`CCSS_SRE_ESB_BIT];
      srq_mask_q[`CCSS_SRE_MAV_BIT] <= cmd.arg[`CCSS_SRE_MAV_BIT];
      srq_mask_q[`CCSS_SRE_LOW_BIT] <= cmd.arg[`CCSS_SRE_LOW_BIT];
    end
  end

  // Checks
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence opc_expiring;
    state_q == ccss_pkg::st_wait && cnt_q == 28'h0 && !cancel && !is_sreq;
  endsequence

  opc_reply_a: assert property (opc_expiring |=> resp_valid_q
    && resp_data_q == `CCSS_ASCII_ONE && state_q == ccss_pkg::st_idle)
    else $error("completion reply missing");
  opc_cancel_a: assert property (state_q != ccss_pkg::st_idle && cancel && !is_sreq
    |=> state_q == ccss_pkg::st_idle && !resp_valid_q)
    else $error("completion wait not cancelled");
  recall_load_a: assert property (rcl_ok && !is_rst |=> active_q == $past(pick))
    else $error("recall did not load location");
  recall_std_a: assert property (rcl_ok && loc == 5'h00 |=> active_q == std_setting())
    else $error("location zero not standard");
  reset_load_a: assert property (is_rst |=> active_q == std_setting()
    && key_queue_clear_q ##1 key_queue_clear_q == $past(is_rst))
    else $error("reset did not restore setting");
  keep_sre_a: assert property (is_rst || is_cls |=> $stable(sre_q))
    else $error("enable register disturbed");
  save_store_a: assert property (sav_ok |=> store_q[$past(loc)] == $past(active_q))
    else $error("save did not store setting");
  sre_write_a: assert property (is_srew |=> sre_q == $past(cmd.arg)
    && srq_mask_q == ($past(cmd.arg) & 8'h71))
    else $error("enable write lost");
  sre_query_a: assert property (is_sreq ##1 !is_srew
    |-> resp_valid_q && resp_data_q == sre_q)
    else $error("enable query wrong");
  range_reject_a: assert property (bad_loc && !is_rst
    |=> $stable(active_q) && cmd_error_q)
    else $error("bad location accepted");

  // Sequencer steps; each one is checked on its own edge
  sequence opc_draining;
    state_q == ccss_pkg::st_drain && queue_empty && !cancel;
  endsequence

  sequence opc_backlogged;
    state_q == ccss_pkg::st_drain && !queue_empty && !cancel;
  endsequence

  sequence opc_counting;
    state_q == ccss_pkg::st_wait && cnt_q != 28'h0 && !cancel;
  endsequence

  // Expiry that meets an enable query; the query reply must not be lost
  sequence opc_collision;
    state_q == ccss_pkg::st_wait && cnt_q == 28'h0 && !cancel && is_sreq;
  endsequence

  opc_start_a: assert property (is_opc && !dev_clear && state_q == ccss_pkg::st_idle
    |=> state_q == ccss_pkg::st_drain)
    else $error("completion query not taken");
  opc_hold_a: assert property (opc_backlogged |=> state_q == ccss_pkg::st_drain)
    else $error("wait began before input drained");
  opc_load_a: assert property (opc_draining |=> state_q == ccss_pkg::st_wait
    && cnt_q == 28'(OPC_WAIT_CYCLES - 1))
    else $error("completion wait not loaded");
  opc_count_a: assert property (opc_counting |=> state_q == ccss_pkg::st_wait
    && cnt_q == $past(cnt_q) - 28'h1)
    else $error("completion count stalled");
  opc_defer_a: assert property (opc_collision |=> resp_valid_q
    && resp_data_q == $past(sre_q) && state_q == ccss_pkg::st_wait && cnt_q == 28'h0)
    else $error("deferred completion lost");
  opc_twice_a: assert property (is_opc && state_q != ccss_pkg::st_idle |=> cmd_error_q)
    else $error("second query not flagged");
  busy_track_a: assert property (1'b1
    |=> opc_busy_q == ($past(state_q) != ccss_pkg::st_idle))
    else $error("busy flag out of step");
  cancel_idle_a: assert property (cancel |-> ##2 !opc_busy_q)
    else $error("busy after cancel");

  // Quiet outputs: nothing moves without its command
  reply_quiet_a: assert property (!opc_done && !is_sreq
    |=> !resp_valid_q && $stable(resp_data_q))
    else $error("unrequested reply");
  error_quiet_a: assert property (!bad_loc && !(is_opc && state_q != ccss_pkg::st_idle)
    |=> !cmd_error_q)
    else $error("spurious error pulse");
  key_quiet_a: assert property (!is_rst |=> !key_queue_clear_q)
    else $error("spurious key queue flush");
  sre_hold_a: assert property (!is_srew |=> $stable(sre_q) && $stable(srq_mask_q))
    else $error("enable register changed unasked");
  active_hold_a: assert property (!is_rst && !rcl_ok |=> $stable(active_q))
    else $error("setting changed unasked");
  save_keep_a: assert property (is_sav |=> $stable(active_q))
    else $error("save disturbed active setting");

endmodule

`default_nettype wire

// [verif/ccss_host_model.sv]
`timescale 1ns/1ps
`default_nettype none

module ccss_host_model (
  // Clock
  input  wire logic              ref_clk,
  // Command side
  output ccss_pkg::ccss_cmd_type cmd,
  output logic                   queue_empty,
  output logic                   dev_clear
);
  // Idle controller at time zero
  initial begin
    cmd = '0;
    queue_empty = 1'b1;
    dev_clear = 1'b0;
  end

  // One unit per call; the released argument is inverted so stale data is never reused
  task automatic send(input ccss_pkg::ccss_cmd_code_type c, input logic [7:0] a);
    @(posedge ref_clk);
    cmd <= {1'b1, c, a};
    @(posedge ref_clk);
    cmd <= {1'b0, c, ~a};
  endtask

  // Units still queued ahead of a query
  task automatic backlog(input int n);
    @(posedge ref_clk);
    queue_empty <= 1'b0;
    repeat (n) @(posedge ref_clk);
    queue_empty <= 1'b1;
  endtask

  // Device-clear message for one cycle
  task automatic clear_pulse();
    @(posedge ref_clk);
    dev_clear <= 1'b1;
    @(posedge ref_clk);
    dev_clear <= 1'b0;
  endtask
endmodule

`default_nettype wire

// [verif/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ccss_consts.svh"

module tb_top;
  // Short wait keeps the completion query cheap to simulate
  localparam int N = 20;
  logic                       ref_clk;
  logic                       reset;
  ccss_pkg::ccss_cmd_type     cmd;
  logic                       queue_empty, dev_clear;
  logic                       resp_valid_q, cmd_error_q, opc_busy_q, key_queue_clear_q;
  logic [7:0]                 resp_data_q, sre_q, srq_mask_q, a;
  ccss_pkg::ccss_setting_type active_q, std_set;
  logic                       e;
  int                         mismatches = 0;
  int                         cmp_count = 0;
  int                         k;
  logic [7:0]                 vals [3] = '{8'hff, 8'h30, 8'h00};
  logic [11:0]                rs [8] = '{12'h100, 12'h113, 12'h114, 12'h201,
                                         12'h213, 12'h200, 12'h214, 12'h1ff};

  ccss_host_model u_host (.ref_clk(ref_clk), .cmd(cmd), .queue_empty(queue_empty),
                          .dev_clear(dev_clear));
  ccss_top #(.OPC_WAIT_CYCLES(N)) u_dut (
    .ref_clk(ref_clk), .reset(reset), .cmd(cmd), .queue_empty(queue_empty),
    .dev_clear(dev_clear), .resp_valid_q(resp_valid_q), .resp_data_q(resp_data_q),
    .cmd_error_q(cmd_error_q), .opc_busy_q(opc_busy_q),
    .key_queue_clear_q(key_queue_clear_q), .active_q(active_q), .sre_q(sre_q),
    .srq_mask_q(srq_mask_q));

  // 125 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // Expected standard setting, built field by field
  initial begin
    std_set = '0;
    std_set.thresh_mv = `CCSS_RST_THRESH_MV;
    std_set.burst_count = `CCSS_RST_COUNT;
    std_set.period_ns = `CCSS_RST_PERIOD_NS;
    for (int i = 0; i < 2; i++) begin
      std_set.ch[i].width_ns = `CCSS_RST_WIDTH_NS;
      std_set.ch[i].double_ns = `CCSS_RST_DOUBLE_NS;
      std_set.ch[i].duty_pct = `CCSS_RST_DUTY_PCT;
      std_set.ch[i].high_mv = `CCSS_RST_HIGH_MV;
      std_set.ch[i].low_mv = `CCSS_RST_LOW_MV;
    end
  end

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask

  task automatic chks(input ccss_pkg::ccss_setting_type got, input string m);
    cmp_count++;
    if (got !== std_set) begin
      mismatches++;
      $display("wrong value at %0t: %s differs from standard", $time, m);
    end
  endtask

  // Send one command, then look at its effects mid-cycle
  task automatic op(input int c, input logic [7:0] arg);
    u_host.send(ccss_pkg::ccss_cmd_code_type'(c[2:0]), arg);
    @(negedge ref_clk);
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Hang guard, far beyond the roughly 1500 ns the tests need
  initial begin
    #100000;
    mismatches++;
    end_sim();
  end

  initial begin
    reset = 1'b1;
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    @(negedge ref_clk);
    chk8(sre_q, 8'h00, "enable after power-on");
    chks(active_q, "setting after power-on");
    $display("test power_on done");
    // Enable register write, query and summary mask
    foreach (vals[i]) begin
      op(5, vals[i]);
      chk8(sre_q, vals[i], "enable write");
      op(6, 8'h00);
      chk8({7'h00, resp_valid_q}, 8'h01, "query reply");
      chk8(resp_data_q, vals[i], "query data");
      chk8(srq_mask_q, vals[i] & 8'h71, "enable mask");
    end
    $display("test enable done");
    // Recall and save across and beyond their ranges
    foreach (rs[i]) begin
      a = rs[i][7:0];
      e = (rs[i][11:8] == 4'h1) ? (a > 8'h13) : (a == 8'h00 || a > 8'h13);
      op(int'(rs[i][11:8]), a);
      chk8({7'h00, cmd_error_q}, {7'h00, e}, "location check");
      chks(active_q, "setting after store op");
    end
    $display("test store done");
    // Completion query behind a backlog, plus a refused second query
    op(5, 8'h50);
    fork
      u_host.backlog(6);
      begin
        op(0, 8'h00);
        op(0, 8'h00);
        chk8({7'h00, cmd_error_q}, 8'h01, "second query");
      end
    join
    chk8({7'h00, opc_busy_q}, 8'h01, "query pending");
    k = 0;
    while (resp_valid_q !== 1'b1 && k < N + 8) begin
      @(negedge ref_clk);
      k++;
    end
    chk8({7'h00, k >= N + 2 && k <= N + 4}, 8'h01, "reply delay");
    chk8(resp_data_q, 8'h31, "reply byte");
    // Enable query landing on the expiry edge is answered first
    op(0, 8'h00);
    repeat (N - 1) @(negedge ref_clk);
    op(6, 8'h00);
    chk8({7'h00, resp_valid_q}, 8'h01, "query reply at expiry");
    chk8(resp_data_q, 8'h50, "query data at expiry");
    @(negedge ref_clk);
    chk8({7'h00, resp_valid_q}, 8'h01, "deferred reply");
    chk8(resp_data_q, 8'h31, "deferred byte");
    $display("test completion done");
    // Cancel by device clear, reset command and clear command
    for (int j = 0; j < 3; j++) begin
      op(0, 8'h00);
      if (j == 0)
        u_host.clear_pulse();
      else
        op(j + 2, 8'h00);
      if (j == 1)
        chk8({7'h00, key_queue_clear_q}, 8'h01, "key queue clear");
      k = 0;
      repeat (N + 8) begin
        @(negedge ref_clk);
        if (resp_valid_q === 1'b1)
          k++;
      end
      chk8(8'(k), 8'h00, "reply after cancel");
      chk8({7'h00, opc_busy_q}, 8'h00, "idle after cancel");
      chk8(sre_q, 8'h50, "enable kept");
      chks(active_q, "setting after cancel");
    end
    $display("test cancel done");
    end_sim();
  end
endmodule

`default_nettype wire
